// ---- bench/cpu_bus_read_interface_test.sv ----
`timescale 1ns/100ps

module cpu_bus_read_interface_test;
  import rd_bus_pkg::*;

  // ****************************************************************
  // Stimulus, expectations and counters
  // ****************************************************************
  logic              clk, sys_rst, strap, req_valid, req_hit, req_uncached;
  logic              req_instr, word_ready, early_ack, src_valid, src_error, stall;
  logic              req_ready, word_valid, core_release, read_done, read_fault, src_take;
  logic [DATA_W-1:0] req_addr, src_data, word_data, lf, lw, acc_addr;
  logic [LANE_W-1:0] req_lanes, acc_lanes;
  logic              acc_valid, acc_quad;  // Memory end latch outputs
  logic [36:0]       na;             // Expected latch outputs
  logic [38:0]       aq[$];          // Address cycle notes
  logic [31:0]       wq[$];          // Word notes
  logic [1:0]        nd;             // Diagnostic bits after the address cycle
  logic              dchk;           // Diagnostic check pending
  int                failures, cmp_count, n_done, n_fault, n_rel, s, k;

  rd_bus_if bus ();

  cpu_read_end u_cpu_read_end (.clk(clk), .sys_rst(sys_rst), .bus(bus),
    .data_quad_strap(strap), .req_valid(req_valid), .req_ready(req_ready),
    .req_addr(req_addr), .req_lanes(req_lanes), .req_hit(req_hit),
    .req_uncached(req_uncached), .req_instr(req_instr), .word_valid(word_valid),
    .word_ready(word_ready), .word_data(word_data), .core_release(core_release),
    .read_done(read_done), .read_fault(read_fault));

  mem_read_end u_mem_read_end (.clk(clk), .sys_rst(sys_rst), .bus(bus),
    .early_ack(early_ack), .src_valid(src_valid), .src_data(src_data),
    .src_error(src_error), .src_take(src_take), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_lanes(acc_lanes), .acc_quad(acc_quad));

  rd_bus_props u_rd_bus_props (.clk(clk), .sys_rst(sys_rst), .cpu_ad_oe(bus.cpu_ad_oe),
    .rd_strobe(bus.rd_strobe), .ale(bus.ale), .low_addr(bus.low_addr),
    .memory_drive_enable(bus.memory_drive_enable), .burst_n(bus.burst_n),
    .diag(bus.diag), .mem_ad_oe(bus.mem_ad_oe),
    .read_buffer_capture_enable(bus.read_buffer_capture_enable),
    .bus_fault_input(bus.bus_fault_input));

  // Random source
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : conclude

  task automatic bail;
    failures++;
    conclude();
  endtask : bail

  // ****************************************************************
  // Monitors: address cycle, words out, end pulses
  // ****************************************************************
  always @(posedge clk) begin
    if (bus.ale === 1'b1) begin
      check(aq.size() > 0, 1);
      if (aq.size() > 0) begin
        check({bus.ad, bus.burst_n, bus.low_addr, bus.diag}, aq[0][38:2]);
        nd   <= aq[0][1:0];
        na   <= {aq[0][38:11], aq[0][5:4], 2'b00, ~aq[0][10:7], ~aq[0][6]};
        dchk <= 1'b1;
        void'(aq.pop_front());
      end
    end else if (dchk) begin
      check(bus.diag, nd);
      check({acc_valid, acc_addr, acc_lanes, acc_quad}, {1'b1, na});
      dchk <= 1'b0;
    end
    if (word_valid === 1'b1 && word_ready === 1'b1) begin
      check(wq.size() > 0, 1);
      if (wq.size() > 0) check(word_data, wq.pop_front());
    end
    n_done  <= n_done + (read_done === 1'b1);
    n_fault <= n_fault + (read_fault === 1'b1);
    n_rel   <= n_rel + (core_release === 1'b1);
  end

  // Consumer readiness, random unless stalled
  always @(posedge clk) begin
    lw         <= nxt(lw);
    word_ready <= !stall && (lw[0] | lw[1]);
  end

  // ****************************************************************
  // One read: 0 instr miss, 1 data miss stalled, 2 uncached, 3 hit, 4 fault
  // ****************************************************************
  task automatic do_read(input int kind);
    logic [31:0] a;
    logic [3:0]  ln;
    logic        q;
    int          n, i, d0, f0, r0;
    lf = nxt(lf);
    a  = lf;
    ln = (kind == 2) ? (a[7:4] | 4'h1) : 4'hF;
    q  = (kind != 2) && (kind == 0 || strap);
    n  = q ? 4 : 1;
    if (kind != 3) aq.push_back({a[31:4], ~ln, !q, q ? 2'h0 : a[3:2], kind != 2, kind == 0, a[3:2]});
    d0 = n_done;
    f0 = n_fault;
    r0 = n_rel;
    req_valid    <= 1'b1;
    req_addr     <= a;
    req_lanes    <= ln;
    req_hit      <= (kind == 3);
    req_uncached <= (kind == 2);
    req_instr    <= (kind == 0);
    early_ack    <= lf[9];
    i = 0;
    do begin @(posedge clk); i++; end while (req_ready !== 1'b1 && i < 300);
    if (i == 300) bail();
    req_valid <= 1'b0;
    stall     <= (kind == 1);
    if (kind == 3) begin
      repeat (6) @(posedge clk);
      check(bus.rd_strobe, 0);
      return;
    end
    for (int w = 0; w < n; w++) begin
      lf = nxt(lf);
      src_valid <= 1'b1;
      src_data  <= lf;
      src_error <= (kind == 4);
      if (kind != 4) wq.push_back(lf);
      i = 0;
      do begin @(posedge clk); i++; end while (src_take !== 1'b1 && i < 300);
      if (i == 300) bail();
      if (kind == 4) break;
      if (lf[1:0] != 2'h0) begin                                           // Wait states
        src_valid <= 1'b0;
        repeat (lf[1:0]) @(posedge clk);
      end
    end
    src_valid <= 1'b0;
    src_error <= 1'b0;
    i = 0;
    do begin @(posedge clk); i++; end while (n_done == d0 && n_fault == f0 && i < 300);
    if (i == 300) bail();
    repeat (2) @(posedge clk);
    check(n_fault != f0, kind == 4);
    check(n_done != d0, kind != 4);
    if (kind != 4) check(n_rel != r0, 1);
    if (kind == 1) check(req_ready, 0);
    stall <= 1'b0;
  endtask : do_read

  // ****************************************************************
  // Clock and main sequence, one reset per strap value
  // ****************************************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    {sys_rst, strap, req_valid, req_hit, req_uncached, req_instr} = '0;
    {early_ack, src_valid, src_error, stall, dchk} = '0;
    {req_addr, src_data, req_lanes, nd, na} = '0;
    word_ready = 1'b0;
    lf = 32'h39A79F97;
    lw = 32'h39A79F97;
    {failures, cmp_count, n_done, n_fault, n_rel} = '0;
    for (s = 0; s < 2; s++) begin
      sys_rst <= 1'b1;
      strap   <= s[0];
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      for (k = 0; k < 15; k++) do_read(k % 5);
      k = 0;
      while ((wq.size() > 0 || aq.size() > 0) && k < 500) begin @(posedge clk); k++; end
      if (k == 500) bail();
    end
    conclude();
  end

endmodule : cpu_bus_read_interface_test

// ---- bench/rd_bus_props.sv ----
`timescale 1ns/100ps

module rd_bus_props (
  input logic       clk,
  input logic       sys_rst,
  input logic       cpu_ad_oe,
  input logic       rd_strobe,
  input logic       ale,
  input logic [1:0] low_addr,
  input logic       memory_drive_enable,
  input logic       burst_n,
  input logic [1:0] diag,
  input logic       mem_ad_oe,
  input logic       read_buffer_capture_enable,
  input logic       bus_fault_input
);
  // ****************************************************************
  // Read cycle properties
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Address cycle, then the bus turned round
  sequence s_addr; ale && rd_strobe && cpu_ad_oe; endsequence
  sequence s_turn; memory_drive_enable && !cpu_ad_oe && !ale && rd_strobe; endsequence
  // Word sampled while memory may drive
  sequence s_cap; memory_drive_enable && read_buffer_capture_enable; endsequence

  a_bus_turn: assert property (ale |-> s_addr ##1 s_turn)
    else $error("bus turn round wrong");
  a_ale_pulse: assert property (ale |=> !ale)
    else $error("latch strobe longer than one cycle");
  a_no_overlap: assert property (memory_drive_enable |-> rd_strobe && !cpu_ad_oe && !ale)
    else $error("drive enable overlaps processor drive");
  a_mem_waits: assert property (mem_ad_oe |-> memory_drive_enable)
    else $error("memory drives without enable");
  a_quad_start: assert property (ale && !burst_n |-> low_addr == 2'h0)
    else $error("quad counter not at zero");
  a_quad_step: assert property (s_cap ##0 (!burst_n && !bus_fault_input && low_addr != 2'h3)
    |=> low_addr == $past(low_addr) + 2'h1) else $error("quad counter did not advance");
  a_single_addr: assert property (rd_strobe && burst_n && $past(rd_strobe) |-> $stable(low_addr))
    else $error("single word address moved");
  a_burst_hold: assert property (rd_strobe && $past(rd_strobe) |-> $stable(burst_n))
    else $error("burst output changed in a read");
  a_diag_hold: assert property (rd_strobe && !ale && $past(rd_strobe) && !$past(ale)
    |-> $stable(diag)) else $error("diagnostic bits moved");
  a_single_end: assert property (s_cap ##0 burst_n |-> ##[1:2] !rd_strobe)
    else $error("single read not ended");
  a_fault_end: assert property (memory_drive_enable && bus_fault_input |-> ##[1:2] !rd_strobe)
    else $error("faulted read not ended");

endmodule : rd_bus_props

// ---- rtl/cpu_read_end.sv ----
// Functional notes
// - Only misses and uncached references reach the bus
// - Single or quad reads; partial uses lanes
// - Instruction misses quad; data per reset mode
// - Read strobe high throughout each read
// - Address 31:4 and lane strobes on bus
// - Latch strobe directly usable by transparent latches
// - Low address bits, or counter from zero
// - Drive enable only after bus released
// - Address held until strobe drops; no overlap
// - Burst output marks quad reads
// - Capture enable stores word; may end single
// - Acknowledge releases core before burst completes
// - Memory times acknowledge ahead of core need
// - Fast memory acknowledges with first capture
// - Without acknowledge, end after one/four captures
// - Bus fault ends read and raises exception
// - Diagnostic one shows miss versus uncached
// - Diagnostic one then shows address bit 3
// - Diagnostic zero: instruction/data, then bit 2
// - Words from second cycle, any waits buffered
// - Burst low for quad, high for single
// - Capture sampled on edge stores bus word
// - Faulted read writes nothing to the cache; here only words not yet handed out are dropped
`timescale 1ns/100ps

module cpu_read_end
  import rd_bus_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  rd_bus_if.cpu                  bus,
  input  wire logic              data_quad_strap,
  input  wire logic              req_valid,
  output logic                   req_ready,
  input  wire logic [DATA_W-1:0] req_addr,
  input  wire logic [LANE_W-1:0] req_lanes,
  input  wire logic              req_hit,
  input  wire logic              req_uncached,
  input  wire logic              req_instr,
  output logic                   word_valid,
  input  wire logic              word_ready,
  output logic [DATA_W-1:0]      word_data,
  output logic                   core_release,
  output logic                   read_done,
  output logic                   read_fault
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  cpu_state_t        st_q, st_d;            // Transaction state
  logic              first_q;               // Strap not yet caught
  logic              qmode_q, qmode_d;      // Data misses fetched as quads
  logic              quad_q, quad_d;        // Current read is a quad
  logic              rd_q, rd_d;            // Read strobe
  logic              ale_q, ale_d;          // Address latch strobe
  logic              oe_q, oe_d;            // Processor bus drivers on
  logic [DATA_W-1:0] aout_q, aout_d;        // Address phase word
  logic [1:0]        low_q, low_d;          // Low address outputs
  logic              den_q, den_d;          // Memory drive enable
  logic              bn_q, bn_d;            // Burst, active low
  logic [1:0]        diag_q, diag_d;        // Diagnostic outputs
  logic [1:0]        miss_q, miss_d;        // Address bits 3:2 of the reference
  logic [CNT_W-1:0]  cnt_q, cnt_d;          // Captures counted
  logic              rel_q, rel_d;          // Core already released
  logic              relp_q, relp_d;        // Core release pulse
  logic              done_q, done_d;        // Read ended pulse
  logic              flt_q, flt_d;          // Bus error exception pulse
  logic              rdy_q, rdy_d;          // Request ready
  logic              take, flush;           // Capture accepted; drop unread words
  logic [DATA_W-1:0] rb [RB_DEPTH];         // Read buffer
  logic [CNT_W-1:0]  wr_q, wr_d;            // Read buffer fill pointer
  logic [CNT_W-1:0]  rp_q, rp_d;            // Read buffer drain pointer
  logic [DATA_W-1:0] e0_q, e0_d, e1_q, e1_d;  // Output buffer entries
  logic              v0_q, v0_d, v1_q, v1_d;  // Output buffer valid flags
  logic              push, pop;             // Output buffer refill and drain

  // ****************************************************************
  // Transaction sequencer
  // ****************************************************************
  always_comb begin
    st_d   = st_q;
    qmode_d = first_q ? data_quad_strap : qmode_q;  // Caught at first edge after reset
    quad_d = quad_q;
    rd_d   = rd_q;
    ale_d  = 1'b0;
    oe_d   = 1'b0;
    aout_d = aout_q;
    low_d  = low_q;
    den_d  = den_q;
    bn_d   = bn_q;
    diag_d = diag_q;
    miss_d = miss_q;
    cnt_d  = cnt_q;
    rel_d  = rel_q;
    done_d = 1'b0;
    flt_d  = 1'b0;
    wr_d   = wr_q;
    take   = 1'b0;
    flush  = 1'b0;
    unique case (st_q)
      CPU_IDLE: begin
        // Cache hits are consumed without any bus activity
        if (req_valid && rdy_q && !req_hit) begin
          st_d   = CPU_ADDR;
          quad_d = !req_uncached && (req_instr || qmode_q);
          rd_d   = 1'b1;
          ale_d  = 1'b1;
          oe_d   = 1'b1;
          aout_d = {req_addr[DATA_W-1:ADDR_HI_LSB], ~req_lanes};
          low_d  = quad_d ? WORD_FIRST : req_addr[3:2];
          bn_d   = !quad_d;
          diag_d = {!req_uncached, req_instr};
          miss_d = req_addr[3:2];
          cnt_d  = '0;
          rel_d  = 1'b0;
        end
      end
      CPU_ADDR: begin
        // Latch strobe and drivers drop on one edge, enable rises on it
        st_d   = CPU_DATA;
        den_d  = 1'b1;
        diag_d = miss_q;
      end
      CPU_DATA: begin
        if (bus.bus_fault_input) begin
          // Error ends the read at once; words not yet handed out are dropped
          flt_d = 1'b1;
          flush = 1'b1;
          st_d  = CPU_IDLE;
        end else begin
          if (bus.ack) rel_d = 1'b1;
          if (bus.read_buffer_capture_enable) begin
            take  = 1'b1;
            wr_d  = wr_q + 3'h1;
            cnt_d = cnt_q + 3'h1;
            if (quad_q) low_d = low_q + 2'h1;
            if (cnt_q == (quad_q ? QUAD_LAST : SINGLE_LAST)) begin
              // Last word counted stands in for an acknowledge
              done_d = 1'b1;
              rel_d  = 1'b1;
              st_d   = CPU_IDLE;
            end
          end
        end
      end
      default: st_d = CPU_IDLE;
    endcase
    // Leaving the data phase returns every strobe to rest
    if (st_q == CPU_DATA && st_d == CPU_IDLE) begin
      rd_d  = 1'b0;
      den_d = 1'b0;
      bn_d  = 1'b1;
    end
    // One release pulse per read that does not fault, on acknowledge or on the implicit end
    relp_d = rel_d && !rel_q;
  end

  // ****************************************************************
  // Read buffer and two-entry output buffer
  // ****************************************************************
  always_comb begin
    // Output buffer drains the read buffer and stalls when full
    push = (rp_q != wr_q) && !v1_q;
    pop  = v0_q && word_ready;
    rp_d = push ? rp_q + 3'h1 : rp_q;
    e0_d = e0_q;
    e1_d = e1_q;
    v0_d = v0_q;
    v1_d = v1_q;
    if (pop) begin
      e0_d = v1_q ? e1_q : rb[rp_q[1:0]];
      v0_d = v1_q || push;
      v1_d = 1'b0;
    end else if (push && !v0_q) begin
      e0_d = rb[rp_q[1:0]];
      v0_d = 1'b1;
    end else if (push) begin
      e1_d = rb[rp_q[1:0]];
      v1_d = 1'b1;
    end
    if (flush) begin
      rp_d = wr_d;
      v0_d = 1'b0;
      v1_d = 1'b0;
    end
    // A new read waits until every word of the last one is gone
    rdy_d = (st_d == CPU_IDLE) && (rp_d == wr_d) && !v0_d && !v1_d;
  end

  // Bus word stored into the buffer entry the fill pointer names
  always_ff @(posedge clk) begin
    if (take) rb[wr_q[1:0]] <= bus.ad;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q    <= CPU_IDLE;
      first_q <= 1'b1;
      qmode_q <= 1'b0;
      quad_q  <= 1'b0;
      rd_q    <= 1'b0;
      ale_q   <= 1'b0;
      oe_q    <= 1'b0;
      aout_q  <= '0;
      low_q   <= '0;
      den_q   <= 1'b0;
      bn_q    <= 1'b1;
      diag_q  <= '0;
      miss_q  <= '0;
      cnt_q   <= '0;
      rel_q   <= 1'b0;
      relp_q  <= 1'b0;
      done_q  <= 1'b0;
      flt_q   <= 1'b0;
      rdy_q   <= 1'b0;
      wr_q    <= '0;
      rp_q    <= '0;
      e0_q    <= '0;
      e1_q    <= '0;
      v0_q    <= 1'b0;
      v1_q    <= 1'b0;
    end else begin
      st_q    <= st_d;
      first_q <= 1'b0;
      qmode_q <= qmode_d;
      quad_q  <= quad_d;
      rd_q    <= rd_d;
      ale_q   <= ale_d;
      oe_q    <= oe_d;
      aout_q  <= aout_d;
      low_q   <= low_d;
      den_q   <= den_d;
      bn_q    <= bn_d;
      diag_q  <= diag_d;
      miss_q  <= miss_d;
      cnt_q   <= cnt_d;
      rel_q   <= rel_d;
      relp_q  <= relp_d;
      done_q  <= done_d;
      flt_q   <= flt_d;
      rdy_q   <= rdy_d;
      wr_q    <= wr_d;
      rp_q    <= rp_d;
      e0_q    <= e0_d;
      e1_q    <= e1_d;
      v0_q    <= v0_d;
      v1_q    <= v1_d;
    end
  end

  // Outputs straight from flip-flops
  assign bus.cpu_ad_out          = aout_q;
  assign bus.cpu_ad_oe           = oe_q;
  assign bus.rd_strobe           = rd_q;
  assign bus.ale                 = ale_q;
  assign bus.low_addr            = low_q;
  assign bus.memory_drive_enable = den_q;
  assign bus.burst_n             = bn_q;
  assign bus.diag                = diag_q;
  assign req_ready               = rdy_q;
  assign word_valid              = v0_q;
  assign word_data               = e0_q;
  assign core_release            = relp_q;
  assign read_done               = done_q;
  assign read_fault              = flt_q;

endmodule : cpu_read_end

// ---- rtl/mem_read_end.sv ----
`timescale 1ns/100ps

module mem_read_end
  import rd_bus_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  rd_bus_if.mem                  bus,
  input  wire logic              early_ack,
  input  wire logic              src_valid,
  input  wire logic [DATA_W-1:0] src_data,
  input  wire logic              src_error,
  output logic                   src_take,
  output logic                   acc_valid,
  output logic [DATA_W-1:0]      acc_addr,
  output logic [LANE_W-1:0]      acc_lanes,
  output logic                   acc_quad
);

  // ****************************************************************
  // State
  // ****************************************************************
  mem_state_t        st_q, st_d;          // Serving state
  logic [DATA_W-1:0] dout_q, dout_d;      // Word on the bus
  logic              oe_q, oe_d;          // Bus driver enable
  logic              cap_q, cap_d;        // Capture enable pulse
  logic              ack_q, ack_d;        // Acknowledge pulse
  logic              flt_q, flt_d;        // Bus fault pulse
  logic              take_q, take_d;      // Source word taken
  logic [DATA_W-1:0] addr_q, addr_d;      // Latched address
  logic [LANE_W-1:0] lanes_q, lanes_d;    // Latched lanes, active high
  logic              quad_q, quad_d;      // Latched burst kind
  logic [CNT_W-1:0]  cnt_q, cnt_d;        // Words handed over

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d    = st_q;
    dout_d  = dout_q;
    cap_d   = 1'b0;
    ack_d   = 1'b0;
    flt_d   = 1'b0;
    take_d  = 1'b0;
    addr_d  = addr_q;
    lanes_d = lanes_q;
    quad_d  = quad_q;
    cnt_d   = cnt_q;
    unique case (st_q)
      MEM_IDLE: begin
        // Capture address and lanes while the latch strobe is high
        if (bus.ale && bus.rd_strobe) begin
          st_d    = MEM_BUSY;
          addr_d  = {bus.ad[DATA_W-1:ADDR_HI_LSB], bus.low_addr, 2'b00};
          lanes_d = ~bus.ad[LANE_W-1:0];
          quad_d  = ~bus.burst_n;
          cnt_d   = '0;
        end
      end
      MEM_BUSY: begin
        // Words are only offered once the processor has let go of the bus
        if (bus.memory_drive_enable && src_valid && !take_q) begin
          take_d = 1'b1;
          if (src_error) begin
            flt_d = 1'b1;
            st_d  = MEM_IDLE;
          end else begin
            dout_d = src_data;
            cap_d  = 1'b1;
            ack_d  = early_ack && quad_q && (cnt_q == '0);
            cnt_d  = cnt_q + 3'h1;
            addr_d[3:2] = addr_q[3:2] + 2'h1;
            if (cnt_q == (quad_q ? QUAD_LAST : SINGLE_LAST)) begin
              st_d = MEM_IDLE;
            end
          end
        end
      end
    endcase
    // Drive only under the enable, and keep driving through the capture
    oe_d = bus.memory_drive_enable && ((st_d == MEM_BUSY) || cap_d);
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q    <= MEM_IDLE;
      dout_q  <= '0;
      oe_q    <= 1'b0;
      cap_q   <= 1'b0;
      ack_q   <= 1'b0;
      flt_q   <= 1'b0;
      take_q  <= 1'b0;
      addr_q  <= '0;
      lanes_q <= '0;
      quad_q  <= 1'b0;
      cnt_q   <= '0;
    end else begin
      st_q    <= st_d;
      dout_q  <= dout_d;
      oe_q    <= oe_d;
      cap_q   <= cap_d;
      ack_q   <= ack_d;
      flt_q   <= flt_d;
      take_q  <= take_d;
      addr_q  <= addr_d;
      lanes_q <= lanes_d;
      quad_q  <= quad_d;
      cnt_q   <= cnt_d;
    end
  end

  // Outputs straight from flip-flops
  assign bus.mem_ad_out                 = dout_q;
  assign bus.mem_ad_oe                  = oe_q;
  assign bus.read_buffer_capture_enable = cap_q;
  assign bus.ack                        = ack_q;
  assign bus.bus_fault_input            = flt_q;
  assign src_take                       = take_q;
  assign acc_valid                      = (st_q == MEM_BUSY);
  assign acc_addr                       = addr_q;
  assign acc_lanes                      = lanes_q;
  assign acc_quad                       = quad_q;

endmodule : mem_read_end

// ---- rtl/rd_bus_if.sv ----
`timescale 1ns/100ps

interface rd_bus_if;
  import rd_bus_pkg::*;

  // ****************************************************************
  // Processor driven
  // ****************************************************************
  logic [DATA_W-1:0] cpu_ad_out;                  // Address and lane strobes
  logic              cpu_ad_oe;                   // Processor drives the bus
  logic              rd_strobe;                   // Read in progress
  logic              ale;                         // Address latch strobe
  logic [1:0]        low_addr;                    // Word address or burst counter
  logic              memory_drive_enable;         // Memory may drive the bus
  logic              burst_n;                     // Low for a quad read
  logic [1:0]        diag;                        // Diagnostic outputs

  // ****************************************************************
  // Memory driven
  // ****************************************************************
  logic [DATA_W-1:0] mem_ad_out;                  // Read data
  logic              mem_ad_oe;                   // Memory drives the bus
  logic              read_buffer_capture_enable;  // Data valid on the bus
  logic              ack;                         // Read processed
  logic              bus_fault_input;             // Read failed

  // ****************************************************************
  // Resolved bus level, zero when nobody drives
  // ****************************************************************
  logic [DATA_W-1:0] ad;
  assign ad = mem_ad_oe ? mem_ad_out : (cpu_ad_oe ? cpu_ad_out : '0);

  modport cpu (
    output cpu_ad_out, cpu_ad_oe, rd_strobe, ale, low_addr,
    output memory_drive_enable, burst_n, diag,
    input  ad, read_buffer_capture_enable, ack, bus_fault_input
  );

  modport mem (
    output mem_ad_out, mem_ad_oe, read_buffer_capture_enable, ack, bus_fault_input,
    input  ad, rd_strobe, ale, low_addr, memory_drive_enable, burst_n, diag
  );

endinterface : rd_bus_if

// ---- rtl/rd_bus_pkg.sv ----
package rd_bus_pkg;

  // ****************************************************************
  // Bus geometry
  // ****************************************************************
  localparam int          DATA_W       = 32;    // Multiplexed bus width
  localparam int          LANE_W       = 4;     // Byte lane strobes
  localparam int          ADDR_HI_LSB  = 4;     // Lowest address bit on the bus
  localparam int          CNT_W        = 3;     // Word counters and buffer pointers
  localparam logic [1:0]  WORD_FIRST   = 2'h0;  // Burst counter start
  localparam logic [2:0]  QUAD_LAST    = 3'h3;  // Count of the fourth word
  localparam logic [2:0]  SINGLE_LAST  = 3'h0;  // Count of the only word
  localparam int          RB_DEPTH     = 4;     // Read buffer words

  // ****************************************************************
  // State encodings
  // ****************************************************************
  typedef enum logic [1:0] {
    CPU_IDLE = 2'b00,  // No bus read
    CPU_ADDR = 2'b01,  // Address phase, latch strobe high
    CPU_DATA = 2'b10   // Bus turned round, words coming in
  } cpu_state_t;

  typedef enum logic {
    MEM_IDLE = 1'b0,   // Waiting for a latch strobe
    MEM_BUSY = 1'b1    // Serving a latched read
  } mem_state_t;

endpackage : rd_bus_pkg
